// ### rtl/hub_request_handler.sv
// Behaviour
// - port clear is 23h, CLEAR_FEATURE, no data
// - port number from wIndex low byte, nonzero
// - clear disables feature or acknowledges change
// - accept power and six change-bit clears
// - clearing power powers the port off
// - powered-off port rejects clear requests
// - clearing force-accept drops the accept flag
// - force-accept already clear completes unchanged
// - error on bad selector, port, length
// - clearing an already clear feature is fine
// - host ignores answers before configuration
// - descriptor read is A0h, GET_DESCRIPTOR
// - one descriptor, index zero, hub type
// - return min of wLength and length
// - descriptor read errors on bad wValue/wIndex
// - status read A0h, GET_STATUS, length four
// - status word first, change word second
// - status read errors on bad fields
// - status bit 0 is local supply lost
// - bit 1 only for hub-wide over-current
// - hub over-current only when truly overloaded
// - change bits cleared by bus reset
// - selectors power 8, connection 16, reset 20
//
// The placing of the registers and register access over APB were chosen for this implementation.
module hub_request_handler
  import hub_req_pkg::*;
#(
  parameter int NPORTS = 4,
  parameter bit HUB_OC_REPORT = 1'b1 // hub-wide over-current detection fitted
) (
  input wire logic clock,
  input wire logic srst,
  hub_req_if.hub_end link,
  input wire logic local_power_lost, // pin, asynchronous
  input wire logic hub_over_current, // pin, asynchronous
  input wire logic [NPORTS-1:0] port_power_set, // pulses from port power logic
  input wire logic [NPORTS-1:0] linkpm_accept_set, // pulses from link logic
  input wire logic [NPORTS*CHG_KINDS-1:0] port_change_set, // change events
  output logic [NPORTS-1:0] port_power_q, // port in powered state
  output logic [NPORTS-1:0] linkpm_accept_q, // forced accept flag in lmps
  output logic [NPORTS*CHG_KINDS-1:0] port_change_q, // sticky change bits
  output logic [15:0] hub_status_word, // current hub status
  output logic [15:0] hub_change_q // current hub change bits
);
  // ****************************************
  // declarations
  // ****************************************
  typedef enum logic [1:0] {st_idle, st_decode, st_send} state_type;
  state_type state_q; // request sequencer
  logic [7:0] rtype_q, breq_q; // latched setup
  logic [15:0] value_q, index_q, length_q;
  logic [7:0] count_q; // bytes sent
  logic [7:0] total_d; // bytes to send
  logic [1:0] lp_sync_q, oc_sync_q; // pin synchronisers
  logic is_clear, is_desc, is_status; // request kind
  logic sel_defined; // selector in the port feature table
  logic port_ok; // port exists and is powered
  logic req_err; // request error
  logic clear_go; // apply the clear this cycle
  logic [7:0] port_num; // addressed port
  logic [7:0] desc_byte, byte_d; // outgoing byte
  logic [31:0] status_bytes; // status response, byte 0 in low bits

  // ****************************************
  // request decode
  // ****************************************
  assign port_num = index_q[7:0];
  assign is_clear = rtype_q == RT_PORT_CLEAR && breq_q == BR_CLEAR_FEATURE;
  assign is_desc = rtype_q == RT_HUB_GET && breq_q == BR_GET_DESCRIPTOR;
  assign is_status = rtype_q == RT_HUB_GET && breq_q == BR_GET_STATUS;

  // selector must be a defined port feature
  always_comb begin
    case (value_q)
      FS_PORT_CONNECTION, FS_PORT_OVER_CURRENT, FS_PORT_RESET, FS_PORT_LINK_STATE,
      FS_PORT_POWER, FS_C_PORT_CONNECTION, FS_C_PORT_OVER_CURRENT, FS_C_PORT_RESET,
      FS_U1_TIMEOUT, FS_U2_TIMEOUT, FS_C_PORT_LINK_STATE, FS_C_PORT_CONFIG_ERROR,
      FS_REMOTE_WAKE_MASK, FS_BH_PORT_RESET, FS_C_BH_PORT_RESET,
      FS_FORCE_LINKPM_ACCEPT: sel_defined = 1'b1;
      default: sel_defined = 1'b0;
    endcase
  end

  // port exists and, for any clear, is still powered
  always_comb begin
    port_ok = 1'b0;
    for (int i = 0; i < NPORTS; i++) begin
      if (port_num == 8'(i + 1) && port_power_q[i]) begin
        port_ok = 1'b1;
      end
    end
  end

  // error check per request kind
  always_comb begin
    if (is_clear) begin
      req_err = !sel_defined || !port_ok || length_q != 16'h0000;
    end else if (is_desc) begin
      req_err = value_q != {DESC_TYPE, 8'h00} || index_q != 16'h0000;
    end else if (is_status) begin
      req_err = value_q != 16'h0000 || index_q != 16'h0000 || length_q != HUB_STATUS_LEN;
    end else begin
      req_err = 1'b1; // outside this block's requests
    end
  end
  assign clear_go = state_q == st_decode && is_clear && !req_err;
  // shorter of request length and response length
  always_comb begin
    if (is_desc) begin
      total_d = (length_q < 16'(DESC_LEN)) ? length_q[7:0] : DESC_LEN;
    end else begin
      total_d = HUB_STATUS_LEN[7:0];
    end
  end

  // ****************************************
  // response data
  // ****************************************
  hub_desc_rom #(.NPORTS(NPORTS)) hub_desc_rom_i (
    .index(count_q),
    .data(desc_byte)
  );
  assign status_bytes = {hub_change_q, hub_status_word};
  // byte select for the response stream
  always_comb begin
    if (is_desc) begin
      byte_d = desc_byte;
    end else begin
      byte_d = status_bytes[{count_q[1:0], 3'b000} +: 8];
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // idle -> decode -> (send) -> idle
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= st_idle;
      count_q <= 8'h00;
      link.rsp_valid <= 1'b0;
      link.rsp_data <= 8'h00;
      link.rsp_done <= 1'b0;
      link.rsp_error <= 1'b0;
    end else begin
      link.rsp_valid <= 1'b0;
      link.rsp_done <= 1'b0;
      case (state_q)
        st_idle: begin
          count_q <= 8'h00;
          if (link.req_valid) begin
            state_q <= st_decode;
          end
        end
        st_decode: begin
          link.rsp_error <= req_err;
          if (req_err || is_clear || total_d == 8'h00) begin
            link.rsp_done <= 1'b1; // clear has no data stage
            state_q <= st_idle;
          end else begin
            state_q <= st_send;
          end
        end
        st_send: begin
          link.rsp_valid <= 1'b1;
          link.rsp_data <= byte_d;
          count_q <= count_q + 8'h01;
          if (count_q + 8'h01 == total_d) begin
            link.rsp_done <= 1'b1;
            state_q <= st_idle;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // setup capture
  always_ff @(posedge clock) begin
    if (srst) begin
      rtype_q <= 8'h00;
      breq_q <= 8'h00;
      value_q <= 16'h0000;
      index_q <= 16'h0000;
      length_q <= 16'h0000;
    end else if (state_q == st_idle && link.req_valid) begin
      rtype_q <= link.bm_request_type;
      breq_q <= link.b_request;
      value_q <= link.w_value;
      index_q <= link.w_index;
      length_q <= link.w_length;
    end
  end

  // ****************************************
  // per-port feature state
  // ****************************************
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic hit; // clear aimed at this port
    assign hit = clear_go && port_num == 8'(p + 1);
    // power: clearing forces powered-off, set pulse wins
    always_ff @(posedge clock) begin
      if (srst) begin
        port_power_q[p] <= PORT_POWER_RESET;
      end else if (port_power_set[p]) begin
        port_power_q[p] <= 1'b1;
      end else if (hit && value_q == FS_PORT_POWER) begin
        port_power_q[p] <= 1'b0;
      end
    end
    // forced accept: clearing when already clear changes nothing
    always_ff @(posedge clock) begin
      if (srst) begin
        linkpm_accept_q[p] <= 1'b0;
      end else if (linkpm_accept_set[p]) begin
        linkpm_accept_q[p] <= 1'b1;
      end else if (hit && value_q == FS_FORCE_LINKPM_ACCEPT) begin
        linkpm_accept_q[p] <= 1'b0;
      end
    end
    for (genvar k = 0; k < CHG_KINDS; k++) begin : g_chg
      logic [15:0] sel; // selector that acknowledges this change
      assign sel = (k == CHG_CONN) ? FS_C_PORT_CONNECTION
        : (k == CHG_OVER_CURRENT) ? FS_C_PORT_OVER_CURRENT
        : (k == CHG_RESET) ? FS_C_PORT_RESET
        : (k == CHG_LINK_STATE) ? FS_C_PORT_LINK_STATE
        : (k == CHG_CONFIG_ERROR) ? FS_C_PORT_CONFIG_ERROR : FS_C_BH_PORT_RESET;
      // sticky change bit, new event beats acknowledge
      always_ff @(posedge clock) begin
        if (srst) begin
          port_change_q[p*CHG_KINDS+k] <= 1'b0;
        end else if (port_change_set[p*CHG_KINDS+k]) begin
          port_change_q[p*CHG_KINDS+k] <= 1'b1;
        end else if (hit && value_q == sel) begin
          port_change_q[p*CHG_KINDS+k] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // hub status and change
  // ****************************************
  // two-flop synchronisers for the supply and over-current pins
  always_ff @(posedge clock) begin
    if (srst) begin
      lp_sync_q <= 2'b00;
      oc_sync_q <= 2'b00;
    end else begin
      lp_sync_q <= {lp_sync_q[0], local_power_lost};
      oc_sync_q <= {oc_sync_q[0], hub_over_current};
    end
  end

  // status word and sticky change bits; over-current only with hub-wide detection
  always_ff @(posedge clock) begin
    if (srst) begin
      hub_status_word <= 16'h0000;
      hub_change_q <= 16'h0000;
    end else begin
      hub_status_word <= 16'h0000;
      hub_status_word[HS_LOCAL_POWER] <= lp_sync_q[1];
      hub_status_word[HS_OVER_CURRENT] <= HUB_OC_REPORT & oc_sync_q[1];
      // change: new synced level differs from the stored status bit
      if (lp_sync_q[1] != hub_status_word[HS_LOCAL_POWER]) begin
        hub_change_q[HS_LOCAL_POWER] <= 1'b1;
      end
      if ((HUB_OC_REPORT & oc_sync_q[1]) != hub_status_word[HS_OVER_CURRENT]) begin
        hub_change_q[HS_OVER_CURRENT] <= 1'b1;
      end
    end
  end
endmodule

// ### rtl/hub_req_pkg.sv
package hub_req_pkg;
  // ****************************************
  // setup field encodings
  // ****************************************
  localparam logic [7:0] RT_PORT_CLEAR = 8'h23; // host-to-device, class, other
  localparam logic [7:0] RT_HUB_GET = 8'hA0; // device-to-host, class, device
  localparam logic [7:0] BR_GET_STATUS = 8'h00;
  localparam logic [7:0] BR_CLEAR_FEATURE = 8'h01;
  localparam logic [7:0] BR_GET_DESCRIPTOR = 8'h06;

  // ****************************************
  // port feature selectors
  // ****************************************
  localparam logic [15:0] FS_PORT_CONNECTION = 16'h0000;
  localparam logic [15:0] FS_PORT_OVER_CURRENT = 16'h0003;
  localparam logic [15:0] FS_PORT_RESET = 16'h0004;
  localparam logic [15:0] FS_PORT_LINK_STATE = 16'h0005;
  localparam logic [15:0] FS_PORT_POWER = 16'h0008;
  localparam logic [15:0] FS_C_PORT_CONNECTION = 16'h0010;
  localparam logic [15:0] FS_C_PORT_OVER_CURRENT = 16'h0013;
  localparam logic [15:0] FS_C_PORT_RESET = 16'h0014;
  localparam logic [15:0] FS_U1_TIMEOUT = 16'h0017;
  localparam logic [15:0] FS_U2_TIMEOUT = 16'h0018;
  localparam logic [15:0] FS_C_PORT_LINK_STATE = 16'h0019;
  localparam logic [15:0] FS_C_PORT_CONFIG_ERROR = 16'h001A;
  localparam logic [15:0] FS_REMOTE_WAKE_MASK = 16'h001B;
  localparam logic [15:0] FS_BH_PORT_RESET = 16'h001C;
  localparam logic [15:0] FS_C_BH_PORT_RESET = 16'h001D;
  localparam logic [15:0] FS_FORCE_LINKPM_ACCEPT = 16'h001E;

  // ****************************************
  // per-port change bit positions
  // ****************************************
  localparam int CHG_KINDS = 6;
  localparam int CHG_CONN = 0;
  localparam int CHG_OVER_CURRENT = 1;
  localparam int CHG_RESET = 2;
  localparam int CHG_LINK_STATE = 3;
  localparam int CHG_CONFIG_ERROR = 4;
  localparam int CHG_BH_RESET = 5;

  // ****************************************
  // hub status and descriptor
  // ****************************************
  localparam int HS_LOCAL_POWER = 0; // status and change bit
  localparam int HS_OVER_CURRENT = 1;
  localparam logic [15:0] HUB_STATUS_LEN = 16'h0004;
  localparam logic [7:0] DESC_TYPE = 8'h2A; // hub descriptor type code
  localparam logic [7:0] DESC_LEN = 8'h0C; // bytes in the hub descriptor
  localparam logic PORT_POWER_RESET = 1'b1; // ports powered after reset

  // ****************************************
  // controller register map (apb)
  // ****************************************
  localparam logic [7:0] REG_SETUP_LO = 8'h00; // {wValue, bRequest, bmRequestType}
  localparam logic [7:0] REG_SETUP_HI = 8'h04; // {wLength, wIndex}
  localparam logic [7:0] REG_CONTROL = 8'h08; // write bit 0: launch
  localparam logic [7:0] REG_STATUS = 8'h0C; // busy, error, byte count
  localparam logic [7:0] REG_DATA = 8'h10; // first four bytes returned
  localparam int ST_BUSY = 0;
  localparam int ST_ERROR = 1;
  localparam int ST_COUNT_LSB = 8;
endpackage

// ### rtl/hub_req_if.sv
// control pipe between the host controller and the hub request handler
interface hub_req_if;
  logic req_valid; // one-cycle pulse, fields held until rsp_done
  logic [7:0] bm_request_type;
  logic [7:0] b_request;
  logic [15:0] w_value;
  logic [15:0] w_index;
  logic [15:0] w_length;
  logic rsp_valid; // one data byte this cycle
  logic [7:0] rsp_data;
  logic rsp_done; // one-cycle pulse ends the request
  logic rsp_error; // request error (stall), valid with rsp_done

  modport hub_end (
    input req_valid, bm_request_type, b_request, w_value, w_index, w_length,
    output rsp_valid, rsp_data, rsp_done, rsp_error
  );
  modport host_end (
    output req_valid, bm_request_type, b_request, w_value, w_index, w_length,
    input rsp_valid, rsp_data, rsp_done, rsp_error
  );
endinterface

// ### rtl/hub_desc_rom.sv
// hub descriptor byte lookup, combinational
module hub_desc_rom
  import hub_req_pkg::*;
#(
  parameter int NPORTS = 4
) (
  input wire logic [7:0] index,
  output logic [7:0] data
);
  // ****************************************
  // descriptor content
  // ****************************************
  // only length, type and port count carry content; the rest reads zero
  always_comb begin
    case (index)
      8'h00: data = DESC_LEN;
      8'h01: data = DESC_TYPE;
      8'h02: data = 8'(NPORTS);
      default: data = 8'h00;
    endcase
  end
endmodule

// ### rtl/hub_host_ctrl.sv
// host end: apb registers drive control requests into the hub
module hub_host_ctrl
  import hub_req_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  hub_req_if.host_end link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ****************************************
  // declarations
  // ****************************************
  logic [31:0] setup_lo_q, setup_hi_q; // request fields
  logic busy_q, error_q; // request state
  logic [7:0] count_q; // bytes received
  logic [31:0] data_q; // first four bytes
  logic access; // apb access completes this edge
  logic mapped; // address decodes
  logic [31:0] rd_d; // read mux

  assign access = psel && penable && pready;
  assign mapped = paddr == REG_SETUP_LO || paddr == REG_SETUP_HI || paddr == REG_CONTROL
    || paddr == REG_STATUS || paddr == REG_DATA;

  // read mux, unmapped reads zero
  always_comb begin
    case (paddr)
      REG_SETUP_LO: rd_d = setup_lo_q;
      REG_SETUP_HI: rd_d = setup_hi_q;
      REG_STATUS: rd_d = {16'h0000, count_q, 6'b000000, error_q, busy_q};
      REG_DATA: rd_d = data_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // apb slave, one wait state
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= rd_d;
    end
  end

  // setup registers; held while busy so the hub sees stable fields
  always_ff @(posedge clock) begin
    if (srst) begin
      setup_lo_q <= 32'h0000_0000;
      setup_hi_q <= 32'h0000_0000;
    end else if (access && pwrite && !busy_q) begin
      if (paddr == REG_SETUP_LO) begin
        setup_lo_q <= pwdata;
      end
      if (paddr == REG_SETUP_HI) begin
        setup_hi_q <= pwdata;
      end
    end
  end

  // ****************************************
  // request launch and response capture
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      link.req_valid <= 1'b0;
      busy_q <= 1'b0;
      error_q <= 1'b0;
      count_q <= 8'h00;
      data_q <= 32'h0000_0000;
    end else begin
      link.req_valid <= 1'b0;
      if (access && pwrite && paddr == REG_CONTROL && pwdata[0] && !busy_q) begin
        link.req_valid <= 1'b1; // launch
        busy_q <= 1'b1;
        error_q <= 1'b0;
        count_q <= 8'h00;
        data_q <= 32'h0000_0000;
      end else begin
        if (link.rsp_valid) begin
          count_q <= count_q + 8'h01;
          if (count_q < 8'h04) begin
            data_q[{count_q[1:0], 3'b000} +: 8] <= link.rsp_data;
          end
        end
        if (link.rsp_done) begin
          busy_q <= 1'b0;
          error_q <= link.rsp_error;
        end
      end
    end
  end

  assign link.bm_request_type = setup_lo_q[7:0];
  assign link.b_request = setup_lo_q[15:8];
  assign link.w_value = setup_lo_q[31:16];
  assign link.w_index = setup_hi_q[15:0];
  assign link.w_length = setup_hi_q[31:16];
endmodule

// ### testbench/hub_class_request_handler_chk.sv
// ****
// protocol checks on the hub request link
// ****
module hub_class_request_handler_chk
  import hub_req_pkg::*;
#(
  parameter int NPORTS = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic [7:0] bm_request_type,
  input wire logic [7:0] b_request,
  input wire logic [15:0] w_value,
  input wire logic [15:0] w_index,
  input wire logic [15:0] w_length,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_done,
  input wire logic rsp_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clr_req; // port clear taken
  logic desc_req; // descriptor read taken
  logic desc_ok; // descriptor read, fields good
  logic stat_req; // hub status read taken
  logic stat_ok; // status fields good
  assign clr_req = req_valid && bm_request_type == RT_PORT_CLEAR
    && b_request == BR_CLEAR_FEATURE;
  assign desc_req = req_valid && bm_request_type == RT_HUB_GET
    && b_request == BR_GET_DESCRIPTOR;
  assign desc_ok = desc_req && w_value == {DESC_TYPE, 8'h00} && w_index == 16'h0000;
  assign stat_req = req_valid && bm_request_type == RT_HUB_GET && b_request == BR_GET_STATUS;
  assign stat_ok = w_value == 16'h0000 && w_index == 16'h0000 && w_length == HUB_STATUS_LEN;
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  // ****
  // assertions
  // ****
  a_clear_no_data: assert property (clr_req |-> ##2 rsp_done && !rsp_valid)
    else $error("port clear answered with data or late");
  a_bad_port_err: assert property (clr_req && (w_index[7:0] == 8'h00
    || w_index[7:0] > 8'(NPORTS)) |-> ##2 rsp_done && rsp_error)
    else $error("bad port number not refused");
  a_clear_len_err: assert property (clr_req && w_length != 16'h0000
    |-> ##2 rsp_done && rsp_error)
    else $error("port clear with length not refused");
  a_desc_bad_err: assert property (desc_req && !desc_ok |-> ##2 rsp_done && rsp_error)
    else $error("bad descriptor read not refused");
  a_desc_zero_len: assert property (desc_ok && w_length == 16'h0000
    |-> ##2 rsp_done && !rsp_valid && !rsp_error)
    else $error("zero length descriptor read wrong");
  a_desc_head: assert property (desc_ok && w_length >= 16'h0002
    |-> ##3 rsp_valid && !rsp_done && rsp_data == DESC_LEN
    ##1 rsp_valid && rsp_data == DESC_TYPE)
    else $error("descriptor head bytes wrong");
  a_stat_bad_err: assert property (stat_req && !stat_ok |-> ##2 rsp_done && rsp_error)
    else $error("bad status read not refused");
  a_stat_four: assert property (stat_req && stat_ok
    |-> ##3 (rsp_valid && !rsp_done)[*3] ##1 (rsp_valid && rsp_done && !rsp_error))
    else $error("status read not four bytes");
  a_err_no_data: assert property (rsp_done && rsp_error |-> !rsp_valid)
    else $error("refused request carried data");
endmodule

// ### testbench/hub_class_request_handler_bench.sv
module hub_class_request_handler_bench;
  import hub_req_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = 4; // ports under test
  logic clock, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic local_power_lost, hub_over_current;
  logic [NP-1:0] port_power_set, linkpm_accept_set, port_power_q, linkpm_accept_q;
  logic [NP*CHG_KINDS-1:0] port_change_set, port_change_q;
  logic [15:0] hub_status_word, hub_change_q;
  int n_mismatch, total_checks;
  hub_req_if link();
  hub_host_ctrl hub_host_ctrl_i (.clock(clock), .srst(srst), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  hub_request_handler #(.NPORTS(NP)) hub_request_handler_i (.clock(clock), .srst(srst),
    .link(link), .local_power_lost(local_power_lost), .hub_over_current(hub_over_current),
    .port_power_set(port_power_set), .linkpm_accept_set(linkpm_accept_set),
    .port_change_set(port_change_set), .port_power_q(port_power_q),
    .linkpm_accept_q(linkpm_accept_q), .port_change_q(port_change_q),
    .hub_status_word(hub_status_word), .hub_change_q(hub_change_q));
  hub_class_request_handler_chk #(.NPORTS(NP)) chk_i (.clock(clock), .srst(srst),
    .req_valid(link.req_valid), .bm_request_type(link.bm_request_type),
    .b_request(link.b_request), .w_value(link.w_value), .w_index(link.w_index),
    .w_length(link.w_length), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
    .rsp_done(link.rsp_done), .rsp_error(link.rsp_error));
  // ****
  // clock, verdict and compare
  // ****
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer, idle cycle first
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // launch one request and judge status, count and first data word
  task req(input logic [7:0] bm, input logic [7:0] br, input logic [15:0] wv,
    input logic [15:0] wi, input logic [15:0] wl, input logic xerr, input logic [7:0] xcnt,
    input logic [31:0] xdat);
    logic [31:0] r, m;
    logic e;
    apb(1'b1, REG_SETUP_LO, {wv, br, bm}, r, e);
    apb(1'b1, REG_SETUP_HI, {wl, wi}, r, e);
    apb(1'b1, REG_CONTROL, 32'h0000_0001, r, e);
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000, r, e);
    end while (r[ST_BUSY] !== 1'b0);
    chk(32'(r[ST_ERROR]), 32'(xerr), "error flag");
    chk(32'(r[ST_COUNT_LSB +: 8]), 32'(xcnt), "byte count");
    apb(1'b0, REG_DATA, 32'h0000_0000, r, e);
    m = (xcnt >= 8'h04) ? 32'hFFFF_FFFF : (32'h0000_0001 << (8 * xcnt)) - 32'h0000_0001;
    chk(r & m, xdat & m, "data word");
  endtask
  // ****
  // scenarios
  // ****
  task t_reset();
    chk(32'(port_power_q), 32'hF, "power after reset");
    chk(32'(port_change_q), 32'h0, "port change after reset");
    chk(32'(hub_change_q), 32'h0, "hub change after reset");
    chk(32'(hub_status_word), 32'h0, "hub status idle");
  endtask
  task t_clear();
    logic [15:0] sel [CHG_KINDS];
    sel = '{FS_C_PORT_CONNECTION, FS_C_PORT_OVER_CURRENT, FS_C_PORT_RESET,
      FS_C_PORT_LINK_STATE, FS_C_PORT_CONFIG_ERROR, FS_C_BH_PORT_RESET};
    port_change_set <= '1;
    linkpm_accept_set <= '1;
    @(posedge clock);
    port_change_set <= '0;
    linkpm_accept_set <= '0;
    for (int k = 0; k < CHG_KINDS; k++) begin
      req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, sel[k], 16'(NP), 0, 1'b0, 0, 0);
      chk(32'(port_change_q[(NP-1)*CHG_KINDS+k]), 32'h0, "change cleared");
      req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, sel[k], 16'(NP), 0, 1'b0, 0, 0);
    end
    chk(32'(port_change_q[0]), 32'h1, "other port untouched");
    req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, FS_FORCE_LINKPM_ACCEPT, 1, 0, 1'b0, 0, 0);
    chk(32'(linkpm_accept_q), 32'hE, "accept dropped");
    req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, FS_FORCE_LINKPM_ACCEPT, 1, 0, 1'b0, 0, 0);
    req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, FS_C_PORT_RESET, 0, 0, 1'b1, 0, 0);
    req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, FS_C_PORT_RESET, 16'(NP+1), 0, 1'b1, 0, 0);
    req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, FS_C_PORT_RESET, 1, 1, 1'b1, 0, 0);
    req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, 16'h0015, 1, 0, 1'b1, 0, 0);
    req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, FS_PORT_POWER, 2, 0, 1'b0, 0, 0);
    chk(32'(port_power_q), 32'hD, "port powered off");
    req(RT_PORT_CLEAR, BR_CLEAR_FEATURE, FS_C_PORT_CONNECTION, 2, 0, 1'b1, 0, 0);
    chk(32'(port_change_q[CHG_KINDS]), 32'h1, "off port untouched");
    port_power_set <= 4'h2;
    @(posedge clock);
    port_power_set <= 4'h0;
    @(posedge clock);
    chk(32'(port_power_q), 32'hF, "port powered again");
  endtask
  task t_desc();
    logic [15:0] dv;
    dv = {DESC_TYPE, 8'h00};
    req(RT_HUB_GET, BR_GET_DESCRIPTOR, dv, 0, 0, 1'b0, 0, 0);
    req(RT_HUB_GET, BR_GET_DESCRIPTOR, dv, 0, 2, 1'b0, 2, 32'h2A0C);
    req(RT_HUB_GET, BR_GET_DESCRIPTOR, dv, 0, 16'hFFFF, 1'b0, DESC_LEN,
      {8'h00, 8'(NP), DESC_TYPE, DESC_LEN});
    req(RT_HUB_GET, BR_GET_DESCRIPTOR, {DESC_TYPE, 8'h01}, 0, 9, 1'b1, 0, 0);
    req(RT_HUB_GET, BR_GET_DESCRIPTOR, dv, 1, 9, 1'b1, 0, 0);
  endtask
  task t_status();
    logic [31:0] r;
    logic e;
    local_power_lost <= 1'b1;
    hub_over_current <= 1'b1;
    repeat (6) @(posedge clock);
    chk(32'(hub_status_word), 32'h3, "status pins");
    chk(32'(hub_change_q), 32'h3, "change pins");
    req(RT_HUB_GET, BR_GET_STATUS, 0, 0, 4, 1'b0, 4, 32'h0003_0003);
    req(RT_HUB_GET, BR_GET_STATUS, 1, 0, 4, 1'b1, 0, 0);
    req(RT_HUB_GET, BR_GET_STATUS, 0, 1, 4, 1'b1, 0, 0);
    req(RT_HUB_GET, BR_GET_STATUS, 0, 0, 2, 1'b1, 0, 0);
    local_power_lost <= 1'b0;
    hub_over_current <= 1'b0;
    repeat (6) @(posedge clock);
    req(RT_HUB_GET, BR_GET_STATUS, 0, 0, 4, 1'b0, 4, 32'h0003_0000);
    apb(1'b0, 8'h40, 32'h0000_0000, r, e);
    chk({r[30:0], e}, 32'h1, "unmapped read");
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'(hub_change_q), 32'h0, "change after reset");
  endtask
  // ****
  // main sequence and watchdog
  // ****
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    local_power_lost = 1'b0;
    hub_over_current = 1'b0;
    port_power_set = '0;
    linkpm_accept_set = '0;
    port_change_set = '0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    t_reset();
    t_clear();
    t_desc();
    t_status();
    summarize();
  end
  initial begin
    repeat (30000) @(posedge clock);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule
